// ### include/sar_adc_pkg.sv
// sar_adc_pkg: offsets, field layout, reset values and timing counts
// assumes: a byte-wide special-function register port on the system clock
package sar_adc_pkg;
   // =====================================================
   // register offsets on the byte register port
   localparam logic [7:0] OFS_CONFIG = 8'hBC;
   localparam logic [7:0] OFS_RESULT = 8'hBE;
   localparam logic [7:0] OFS_UPPER = 8'hC6;
   localparam logic [7:0] OFS_LOWER = 8'hC4;
   localparam logic [7:0] OFS_CONTROL = 8'hE8;
   // =====================================================
   // reset values
   localparam logic [7:0] RST_CONFIG = 8'hF8;
   localparam logic [7:0] RST_RESULT = 8'h00;
   localparam logic [7:0] RST_UPPER = 8'h00;
   localparam logic [7:0] RST_LOWER = 8'hFF;
   localparam logic [7:0] RST_CONTROL = 8'h00;
   // =====================================================
   // field positions
   localparam int CFG_DIV_MSB = 7;
   localparam int CFG_DIV_LSB = 3;
   localparam int CFG_GAIN_MSB = 1;
   localparam int CFG_GAIN_LSB = 0;
   localparam int CTL_ENABLE = 7;
   localparam int CTL_LOWPOWER = 6;
   localparam int CTL_DONE = 5;
   localparam int CTL_BUSY = 4;
   localparam int CTL_SRC_MSB = 3;
   localparam int CTL_SRC_LSB = 1;
   localparam int CTL_WINDOW = 0;
   // =====================================================
   // start source codes
   localparam logic [2:0] SRC_SOFTWARE = 3'h0;
   localparam logic [2:0] SRC_TIMER3 = 3'h1;
   localparam logic [2:0] SRC_STROBE = 3'h2;
   localparam logic [2:0] SRC_TIMER2 = 3'h3;
   // =====================================================
   // timing: system clock rate, SAR ceiling, phase lengths in SAR clocks
   localparam int SYS_CLOCK_HZ = 125_000_000;
   localparam int SAR_CLOCK_MAX_HZ = 6_000_000;
   localparam int TRACK_SAR_CLOCKS = 3;
   localparam int CONVERT_SAR_CLOCKS = 8;
   localparam int DIVISOR_WIDTH = 5;
   // =====================================================
   // sequencer states
   typedef enum logic [2:0]
   {
      SEQ_IDLE = 3'b001,
      SEQ_TRACK = 3'b010,
      SEQ_CONVERT = 3'b100
   } seq_state_t;
endpackage

// ### include/conv_core_if.sv
// conv_core_if: link between register logic and conversion sequencer
// assumes: both ends on ref_clk
`timescale 1ns/1ps
`default_nettype none
interface conv_core_if;
   logic enable; // converter powered
   logic start; // accepted start event, one cycle
   logic skipTrack; // go straight to converting
   logic [4:0] divisor; // SAR divisor field
   logic busy; // conversion running
   logic tracking; // timed tracking phase
   logic sarTick; // one pulse per SAR clock
   logic finishing; // last SAR clock of a conversion
   modport ctrl (output enable, start, skipTrack, divisor,
                 input busy, tracking, sarTick, finishing);
   modport seq (input enable, start, skipTrack, divisor,
                output busy, tracking, sarTick, finishing);
endinterface
`default_nettype wire

// ### logic/sar_conversion_sequencer.sv
// sar_conversion_sequencer: SAR clock divider and track/convert sequence
// assumes: start is only raised while not busy and enabled
`timescale 1ns/1ps
`default_nettype none
module sar_conversion_sequencer
(
   input wire logic ref_clk, // system clock
   input wire logic rst_n, // async reset, active low
   conv_core_if.seq link // control side
);
   sar_adc_pkg::seq_state_t state;
   logic [4:0] divCount;
   logic [3:0] phaseCount;

   // =====================================================
   // divider: one tick every divisor+1 cycles, restarted at a start
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         divCount <= 5'h00;
         link.sarTick <= 1'b0;
      end
      else if (!link.enable || link.start)
      begin
         divCount <= 5'h00;
         link.sarTick <= 1'b0;
      end
      else if (divCount >= link.divisor)
      begin
         divCount <= 5'h00;
         link.sarTick <= 1'b1;
      end
      else
      begin
         divCount <= divCount + 5'h01;
         link.sarTick <= 1'b0;
      end
   end

   // last convert tick ends the conversion
   assign link.finishing = (state == sar_adc_pkg::SEQ_CONVERT) && link.sarTick
      && (phaseCount == 4'(sar_adc_pkg::CONVERT_SAR_CLOCKS - 1));
   assign link.tracking = (state == sar_adc_pkg::SEQ_TRACK);

   // =====================================================
   // track then convert; shutdown aborts
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= sar_adc_pkg::SEQ_IDLE;
         phaseCount <= 4'h0;
         link.busy <= 1'b0;
      end
      else if (!link.enable)
      begin
         state <= sar_adc_pkg::SEQ_IDLE;
         phaseCount <= 4'h0;
         link.busy <= 1'b0;
      end
      else
      begin
         unique case (state)
            sar_adc_pkg::SEQ_IDLE:
            begin
               phaseCount <= 4'h0;
               if (link.start)
               begin
                  link.busy <= 1'b1;
                  state <= link.skipTrack ? sar_adc_pkg::SEQ_CONVERT
                     : sar_adc_pkg::SEQ_TRACK;
               end
            end
            sar_adc_pkg::SEQ_TRACK:
            begin
               if (link.sarTick)
               begin
                  if (phaseCount == 4'(sar_adc_pkg::TRACK_SAR_CLOCKS - 1))
                  begin
                     phaseCount <= 4'h0;
                     state <= sar_adc_pkg::SEQ_CONVERT;
                  end
                  else
                     phaseCount <= phaseCount + 4'h1;
               end
            end
            sar_adc_pkg::SEQ_CONVERT:
            begin
               if (link.finishing)
               begin
                  link.busy <= 1'b0;
                  phaseCount <= 4'h0;
                  state <= sar_adc_pkg::SEQ_IDLE;
               end
               else if (link.sarTick)
                  phaseCount <= phaseCount + 4'h1;
            end
            default:
            begin
               link.busy <= 1'b0;
               state <= sar_adc_pkg::SEQ_IDLE;
            end
         endcase
      end
   end
endmodule // sar_conversion_sequencer
`default_nettype wire

// ### logic/sar_adc_control_window.sv
// sar_adc_control_window: register logic, start selection, result and window
// assumes: byte register port, timers and core on ref_clk; strobe is a pin
`timescale 1ns/1ps
`default_nettype none
module sar_adc_control_window
(
   input wire logic ref_clk, // 125 MHz system clock
   input wire logic rst_n, // async reset, active low
   input wire logic [7:0] sfrAddr, // register address
   input wire logic sfrWrite, // write strobe, one cycle
   input wire logic sfrRead, // read strobe, one cycle
   input wire logic [7:0] sfrWdata, // write data
   output logic [7:0] sfrRdata, // read data, one cycle after strobe
   input wire logic timer3Overflow, // timer three overflow pulse
   input wire logic timer2Overflow, // timer two overflow pulse
   input wire logic primaryBusyWrite, // primary converter busy set pulse
   input wire logic externalConvertStrobe, // strobe pin, asynchronous
   input wire logic differentialMode, // channel is a differential pair
   input wire logic [7:0] coreResult, // SAR code from the analog core
   input wire logic doneIrqEnable, // completion interrupt enabled
   output logic doneIrq, // completion interrupt pulse
   output logic [1:0] amplifierGain, // gain code to amplifier
   output logic converterPowered, // analog core out of shutdown
   output logic trackInput, // sample switch closed
   output logic convertPhase, // core in bit decisions
   output logic sarClock // one pulse per SAR clock
);
   // =====================================================
   // register state
   logic [4:0] sarClockDivisor;
   logic [1:0] gainSelect;
   logic converterEnableBit;
   logic lowPowerTrackSelect;
   logic conversionDoneFlag;
   logic [2:0] startSourceSelect;
   logic windowMatchFlag;
   logic [7:0] conversionResult;
   logic [7:0] windowUpperLimit;
   logic [7:0] windowLowerLimit;

   // decoded writes
   logic writeConfig;
   logic writeControl;
   logic writeResult;
   logic writeUpper;
   logic writeLower;
   logic softwareStart;
   logic selectedEvent;
   logic windowHit;

   // strobe synchroniser and edge
   logic strobeMeta;
   logic strobeSync;
   logic strobeLate;
   logic strobeLevel;
   logic strobeRise;

   conv_core_if coreLink();

   // =====================================================
   // window test, shared by both number formats
   function automatic logic inWindow
   (
      input logic [7:0] code,
      input logic [7:0] lower,
      input logic [7:0] upper,
      input logic signedMode
   );
      logic lowBelowUp;
      logic aboveLow;
      logic belowUp;
      begin
         if (signedMode)
         begin
            lowBelowUp = $signed(lower) < $signed(upper);
            aboveLow = $signed(code) > $signed(lower);
            belowUp = $signed(code) < $signed(upper);
         end
         else
         begin
            lowBelowUp = lower < upper;
            aboveLow = code > lower;
            belowUp = code < upper;
         end
         if (lowBelowUp)
            inWindow = aboveLow && belowUp;
         else
            inWindow = belowUp || aboveLow;
      end
   endfunction

   // =====================================================
   // address decode
   assign writeConfig = sfrWrite && (sfrAddr == sar_adc_pkg::OFS_CONFIG);
   assign writeControl = sfrWrite && (sfrAddr == sar_adc_pkg::OFS_CONTROL);
   assign writeResult = sfrWrite && (sfrAddr == sar_adc_pkg::OFS_RESULT);
   assign writeUpper = sfrWrite && (sfrAddr == sar_adc_pkg::OFS_UPPER);
   assign writeLower = sfrWrite && (sfrAddr == sar_adc_pkg::OFS_LOWER);

   // busy write of 1 with software source in the written byte
   assign softwareStart = writeControl && sfrWdata[sar_adc_pkg::CTL_BUSY]
      && (sfrWdata[sar_adc_pkg::CTL_SRC_MSB:sar_adc_pkg::CTL_SRC_LSB]
      == sar_adc_pkg::SRC_SOFTWARE);

   // =====================================================
   // strobe pin: three flops, a change counts when the last two agree
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         strobeMeta <= 1'b1;
         strobeSync <= 1'b1;
         strobeLate <= 1'b1;
         strobeLevel <= 1'b1;
      end
      else
      begin
         strobeMeta <= externalConvertStrobe;
         strobeSync <= strobeMeta;
         strobeLate <= strobeSync;
         if (strobeSync == strobeLate)
            strobeLevel <= strobeLate;
      end
   end

   // a rise lasts one cycle: the filtered level catches up on the next edge
   assign strobeRise = (strobeSync == strobeLate) && strobeLate && !strobeLevel;

   // =====================================================
   // start event selection
   always_comb
   begin
      if (startSourceSelect[2])
         selectedEvent = primaryBusyWrite;
      else
      begin
         unique case (startSourceSelect[1:0])
            2'h0: selectedEvent = softwareStart;
            2'h1: selectedEvent = timer3Overflow;
            2'h2: selectedEvent = strobeRise;
            2'h3: selectedEvent = timer2Overflow;
         endcase
      end
   end

   // a write of the software code starts at once, even as the field changes
   assign coreLink.start = converterEnableBit && !coreLink.busy
      && (softwareStart || (selectedEvent && !writeControl));
   assign coreLink.enable = converterEnableBit;
   assign coreLink.divisor = sarClockDivisor;
   // the strobe low time is the tracking phase, so no timed tracking
   assign coreLink.skipTrack = !lowPowerTrackSelect
      || (startSourceSelect == sar_adc_pkg::SRC_STROBE);

   // sequencer owns busy, the SAR tick and the phase counts
   sar_conversion_sequencer sequencer
   (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .link(coreLink)
   );

   assign windowHit = inWindow(coreResult, windowLowerLimit, windowUpperLimit,
      differentialMode);

   // =====================================================
   // configuration register
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sarClockDivisor <= sar_adc_pkg::RST_CONFIG[7:3];
         gainSelect <= sar_adc_pkg::RST_CONFIG[1:0];
      end
      else if (writeConfig)
      begin
         sarClockDivisor <= sfrWdata[sar_adc_pkg::CFG_DIV_MSB:sar_adc_pkg::CFG_DIV_LSB];
         gainSelect <= sfrWdata[sar_adc_pkg::CFG_GAIN_MSB:sar_adc_pkg::CFG_GAIN_LSB];
      end
   end

   // =====================================================
   // control fields written by software
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         converterEnableBit <= sar_adc_pkg::RST_CONTROL[7];
         lowPowerTrackSelect <= sar_adc_pkg::RST_CONTROL[6];
         startSourceSelect <= sar_adc_pkg::RST_CONTROL[3:1];
      end
      else if (writeControl)
      begin
         converterEnableBit <= sfrWdata[sar_adc_pkg::CTL_ENABLE];
         lowPowerTrackSelect <= sfrWdata[sar_adc_pkg::CTL_LOWPOWER];
         startSourceSelect <= sfrWdata[sar_adc_pkg::CTL_SRC_MSB:sar_adc_pkg::CTL_SRC_LSB];
      end
   end

   // =====================================================
   // done flag: busy fall sets, only software clears, set wins
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         conversionDoneFlag <= sar_adc_pkg::RST_CONTROL[5];
      else if (coreLink.finishing)
         conversionDoneFlag <= 1'b1;
      else if (writeControl)
         conversionDoneFlag <= sfrWdata[sar_adc_pkg::CTL_DONE];
   end

   // =====================================================
   // window flag: a matching result sets, only software clears, set wins
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         windowMatchFlag <= sar_adc_pkg::RST_CONTROL[0];
      else if (coreLink.finishing && windowHit)
         windowMatchFlag <= 1'b1;
      else if (writeControl)
         windowMatchFlag <= sfrWdata[sar_adc_pkg::CTL_WINDOW];
   end

   // =====================================================
   // result byte: taken on the edge where busy falls
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         conversionResult <= sar_adc_pkg::RST_RESULT;
      else if (coreLink.finishing)
         conversionResult <= coreResult;
      else if (writeResult)
         conversionResult <= sfrWdata;
   end

   // =====================================================
   // window limits
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         windowUpperLimit <= sar_adc_pkg::RST_UPPER;
         windowLowerLimit <= sar_adc_pkg::RST_LOWER;
      end
      else
      begin
         if (writeUpper)
            windowUpperLimit <= sfrWdata;
         if (writeLower)
            windowLowerLimit <= sfrWdata;
      end
   end

   // =====================================================
   // read port: registered, unmapped addresses read zero
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         sfrRdata <= 8'h00;
      else if (sfrRead)
      begin
         unique case (sfrAddr)
            sar_adc_pkg::OFS_CONFIG:
               sfrRdata <= {sarClockDivisor, 1'b0, gainSelect};
            sar_adc_pkg::OFS_CONTROL:
               sfrRdata <= {converterEnableBit, lowPowerTrackSelect,
                  conversionDoneFlag, coreLink.busy, startSourceSelect,
                  windowMatchFlag};
            sar_adc_pkg::OFS_RESULT:
               sfrRdata <= conversionResult;
            sar_adc_pkg::OFS_UPPER:
               sfrRdata <= windowUpperLimit;
            sar_adc_pkg::OFS_LOWER:
               sfrRdata <= windowLowerLimit;
            default:
               sfrRdata <= 8'h00;
         endcase
      end
   end

   // =====================================================
   // completion interrupt on the busy fall
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         doneIrq <= 1'b0;
      else
         doneIrq <= coreLink.finishing && doneIrqEnable;
   end

   // =====================================================
   // analog core controls
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         amplifierGain <= 2'h0;
         converterPowered <= 1'b0;
         trackInput <= 1'b0;
         convertPhase <= 1'b0;
         sarClock <= 1'b0;
      end
      else
      begin
         amplifierGain <= gainSelect;
         converterPowered <= converterEnableBit;
         sarClock <= coreLink.sarTick;
         convertPhase <= coreLink.busy && !coreLink.tracking;
         // strobe tracking follows the filtered level, never the raw pin
         if (!converterEnableBit)
            trackInput <= 1'b0;
         else if (!lowPowerTrackSelect)
            trackInput <= !coreLink.busy;
         else if (startSourceSelect == sar_adc_pkg::SRC_STROBE)
            trackInput <= !coreLink.busy && !strobeLevel;
         else
            trackInput <= coreLink.tracking;
      end
   end
endmodule // sar_adc_control_window
`default_nettype wire

// ### tb/sar_adc_control_window_assertions.sv
// checker: port timing of the converter control block
// assumes: bound to sar_adc_control_window, one clock domain
`timescale 1ns/1ps
`default_nettype none
module sar_adc_control_window_assertions
(
   input wire logic ref_clk, // clock
   input wire logic rst_n, // reset
   input wire logic [7:0] sfrAddr, // address
   input wire logic sfrWrite, // write strobe
   input wire logic sfrRead, // read strobe
   input wire logic [7:0] sfrWdata, // write data
   input wire logic [7:0] sfrRdata, // read data
   input wire logic doneIrqEnable, // irq enable
   input wire logic doneIrq, // irq pulse
   input wire logic [1:0] amplifierGain, // gain code
   input wire logic converterPowered, // core powered
   input wire logic trackInput, // tracking
   input wire logic convertPhase // converting
);
   // ========================================
   // helpers and defaults
   logic cfgWr;
   logic [1:0] gainIn;
   assign cfgWr = sfrWrite && sfrAddr == sar_adc_pkg::OFS_CONFIG;
   assign gainIn = sfrWdata[1:0];
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // ========================================
   // properties
   spare_bit_a: assert property (sfrRead && sfrAddr == sar_adc_pkg::OFS_CONFIG |=> !sfrRdata[2])
      else $error("config spare bit read nonzero");
   gain_copy_a: assert property (cfgWr ##1 !sfrWrite |=> amplifierGain == $past(gainIn, 2))
      else $error("gain output not following write");
   gain_hold_a: assert property (!cfgWr [*2] |=> $stable(amplifierGain))
      else $error("gain output changed without write");
   shutdown_a: assert property (!converterPowered [*3] |-> !trackInput && !convertPhase)
      else $error("core active while disabled");
   track_excl_a: assert property (convertPhase |-> !trackInput)
      else $error("tracking during conversion");
   convert_len_a: assert property ($rose(convertPhase) |-> convertPhase [*8])
      else $error("conversion shorter than eight clocks");
   irq_after_a: assert property (doneIrq |-> $past(convertPhase) ##1 !convertPhase)
      else $error("irq without conversion end");
   irq_pulse_a: assert property (doneIrq |-> $past(doneIrqEnable) ##1 !doneIrq)
      else $error("irq masked or too long");
endmodule // sar_adc_control_window_assertions
bind sar_adc_control_window sar_adc_control_window_assertions chk
(
   .ref_clk(ref_clk), .rst_n(rst_n), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
   .sfrRead(sfrRead), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
   .doneIrqEnable(doneIrqEnable), .doneIrq(doneIrq), .amplifierGain(amplifierGain),
   .converterPowered(converterPowered), .trackInput(trackInput), .convertPhase(convertPhase)
);
`default_nettype wire

// ### tb/sar_far_side.sv
// sar_far_side: timers, primary converter, strobe pin and analog core
// assumes: bench calls fire, quiet and arm just after a clock edge
`timescale 1ns/1ps
`default_nettype none
module sar_far_side
(
   input wire logic convertPhase, // core converting
   output logic [7:0] coreResult, // code to block
   output logic timer3Overflow, // timer three
   output logic timer2Overflow, // timer two
   output logic primaryBusyWrite, // primary start
   output var logic externalConvertStrobe // strobe pin
);
   // ========================================
   // event lines and core code
   logic [7:0] code = 8'h00;
   logic [2:0] evt = 3'h0;
   initial externalConvertStrobe = 1'b1;
   assign {primaryBusyWrite, timer2Overflow, timer3Overflow} = evt;
   // core code only settled while converting
   assign coreResult = convertPhase ? code : ~code;
   // one start event per source code
   task automatic fire(input int s);
      case (s)
         1: evt = 3'h1;
         2: externalConvertStrobe = 1'b1;
         3: evt = 3'h2;
         4: evt = 3'h4;
         default: evt = 3'h0;
      endcase
   endtask
   task automatic quiet();
      evt = 3'h0;
   endtask
   task automatic arm();
      externalConvertStrobe = 1'b0;
   endtask
endmodule // sar_far_side
`default_nettype wire

// ### tb/tb_sar_adc_control_window.sv
// tb_sar_adc_control_window: self-checking bench for the converter control
// assumes: far-side model makes timer, strobe and core stimulus
`timescale 1ns/1ps
`default_nettype none
module tb_sar_adc_control_window;
   // ========================================
   // signals
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] sfrAddr = 8'h00;
   logic sfrWrite = 1'b0;
   logic sfrRead = 1'b0;
   logic [7:0] sfrWdata = 8'h00;
   logic differentialMode = 1'b0;
   logic doneIrqEnable = 1'b1;
   logic [7:0] ctl = 8'h00;
   logic rdPend = 1'b0;
   logic [7:0] sfrRdata, coreResult, lo, hi, c;
   logic tmr3, tmr2, priBusy, strobe, doneIrq, converterPowered, trackInput, convertPhase;
   logic [1:0] amplifierGain;
   logic sarClock;
   logic [7:0] expQ[$];
   logic [31:0] tbl[9] = '{32'h10201501, 32'h10201000, 32'h10202000, 32'h20100501,
      32'h20101500, 32'h20102101, 32'hFF100011, 32'hFF108010, 32'hFF100F11};
   int errors = 0;
   int total_checks = 0;
   int cycles = 0;
   int irqs = 0;
   integer seed = 32'heaec;
   sar_adc_control_window uut
   (
      .ref_clk(ref_clk), .rst_n(rst_n), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
      .sfrRead(sfrRead), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .timer3Overflow(tmr3),
      .timer2Overflow(tmr2), .primaryBusyWrite(priBusy), .externalConvertStrobe(strobe),
      .differentialMode(differentialMode), .coreResult(coreResult),
      .doneIrqEnable(doneIrqEnable), .doneIrq(doneIrq), .amplifierGain(amplifierGain),
      .converterPowered(converterPowered), .trackInput(trackInput),
      .convertPhase(convertPhase), .sarClock(sarClock)
   );
   sar_far_side far
   (
      .convertPhase(convertPhase), .coreResult(coreResult), .timer3Overflow(tmr3),
      .timer2Overflow(tmr2), .primaryBusyWrite(priBusy), .externalConvertStrobe(strobe)
   );
   // ========================================
   // clock, read monitor, timeout
   always #4 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      if (rdPend) check(sfrRdata, expQ.pop_front());
      rdPend <= sfrRead;
      irqs = irqs + (doneIrq === 1'b1);
      cycles++;
      if (cycles == 30000)
      begin
         errors++;
         test_done();
      end
   end
   // ========================================
   // tasks
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfrAddr = a;
      sfrWdata = d;
      sfrWrite = 1'b1;
      step(1);
      sfrWrite = 1'b0;
      step(1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      expQ.push_back(e);
      sfrAddr = a;
      sfrRead = 1'b1;
      step(1);
      sfrRead = 1'b0;
      step(1);
   endtask
   // window flag from limits, code and signedness
   function automatic logic winExp(input logic [7:0] l, u, v, input logic d);
      int a, b, x;
      a = d ? int'($signed(l)) : int'(l);
      b = d ? int'($signed(u)) : int'(u);
      x = d ? int'($signed(v)) : int'(v);
      return (a < b) ? (x > a && x < b) : (x < b || x > a);
   endfunction
   // one start from source s, wait for irq, read result and flags
   task automatic convert(input int s, input logic [2:0] f, input logic [7:0] v,
      input int expN, input logic w, input logic rew);
      int n;
      int k;
      n = 0;
      k = 0;
      far.code = v;
      if (rew) wr(sar_adc_pkg::OFS_CONTROL, {ctl[7:4], f, 1'b0});
      if (s == 2) far.arm();
      step(6);
      check(trackInput, !ctl[6] || s == 2);
      sfrAddr = sar_adc_pkg::OFS_CONTROL;
      sfrWdata = {ctl[7:5], 1'b1, f, 1'b0};
      sfrWrite = (s == 0);
      far.fire(s);
      step(1);
      sfrWrite = 1'b0;
      far.quiet();
      while (doneIrq !== 1'b1 && n < 400)
      begin
         step(1);
         n++;
         k += (sarClock === 1'b1);
      end
      if (expN > 0) check(n, expN);
      if (expN > 0) check(k, ctl[6] ? 11 : 8);
      rd(sar_adc_pkg::OFS_RESULT, v);
      rd(sar_adc_pkg::OFS_CONTROL, {ctl[7:6], 2'b10, f, w});
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // ========================================
   // main sequence
   initial
   begin
      step(10);
      rst_n = 1'b1;
      step(1);
      rd(sar_adc_pkg::OFS_CONFIG, sar_adc_pkg::RST_CONFIG);
      rd(sar_adc_pkg::OFS_RESULT, sar_adc_pkg::RST_RESULT);
      rd(sar_adc_pkg::OFS_UPPER, sar_adc_pkg::RST_UPPER);
      rd(sar_adc_pkg::OFS_LOWER, sar_adc_pkg::RST_LOWER);
      rd(sar_adc_pkg::OFS_CONTROL, sar_adc_pkg::RST_CONTROL);
      rd(8'h55, 8'h00);
      check(converterPowered, 1'b0);
      // divisor 20 keeps the SAR clock under 6 MHz; spare bit written high
      for (int g = 0; g < 4; g++)
      begin
         wr(sar_adc_pkg::OFS_CONFIG, 8'hA4 | g[7:0]);
         check(amplifierGain, g[1:0]);
         rd(sar_adc_pkg::OFS_CONFIG, 8'hA0 | g[7:0]);
      end
      ctl = 8'h80;
      wr(sar_adc_pkg::OFS_CONTROL, ctl);
      step(2);
      check(converterPowered, 1'b1);
      check(trackInput, 1'b1);
      // window table, then random limits and codes
      for (int i = 0; i < 13; i++)
      begin
         lo = (i < 9) ? tbl[i][31:24] : 8'($random(seed));
         hi = (i < 9) ? tbl[i][23:16] : 8'($random(seed));
         c = (i < 9) ? tbl[i][15:8] : 8'($random(seed));
         differentialMode = (i < 9) ? tbl[i][4] : 1'($random(seed));
         wr(sar_adc_pkg::OFS_LOWER, lo);
         wr(sar_adc_pkg::OFS_UPPER, hi);
         convert(0, 3'h0, c, 169, (i < 9) ? tbl[i][0] : winExp(lo, hi, c, differentialMode), 1'b1);
      end
      // masked irq, busy seen mid-conversion, flag still set afterwards
      doneIrqEnable = 1'b0;
      far.code = hi;
      c = irqs[7:0];
      wr(sar_adc_pkg::OFS_CONTROL, 8'h90);
      step(40);
      rd(sar_adc_pkg::OFS_CONTROL, 8'h90);
      step(160);
      check(irqs[7:0], c);
      rd(sar_adc_pkg::OFS_CONTROL, 8'hA0);
      doneIrqEnable = 1'b1;
      wr(sar_adc_pkg::OFS_CONTROL, 8'h92);
      step(200);
      rd(sar_adc_pkg::OFS_CONTROL, 8'h82);
      // every source in both track modes
      wr(sar_adc_pkg::OFS_LOWER, 8'h00);
      wr(sar_adc_pkg::OFS_UPPER, 8'hFF);
      differentialMode = 1'b0;
      for (int lp = 0; lp < 2; lp++)
         for (int s = 0; s < 5; s++)
         begin
            ctl = {1'b1, lp[0], 6'h00};
            c = 8'($random(seed));
            convert(s, (s == 4) ? 3'(4 + 3 * lp) : 3'(s), c, (s == 2) ? 0 : (lp ? 232 : 169),
               winExp(8'h00, 8'hFF, c, 1'b0), 1'b1);
         end
      // flag not cleared by a later non-matching result
      convert(1, 3'h1, 8'h40, 232, 1'b1, 1'b1);
      convert(1, 3'h1, 8'hFF, 232, 1'b1, 1'b0);
      // slowest divisor
      ctl = 8'h80;
      wr(sar_adc_pkg::OFS_CONFIG, 8'hF8);
      convert(0, 3'h0, 8'h33, 257, 1'b1, 1'b1);
      test_done();
   end
endmodule // tb_sar_adc_control_window
`default_nettype wire
